// >>> logic/fcsr_defines.vh
`ifndef FCSR_DEFINES_VH
`define FCSR_DEFINES_VH

// Register offsets (byte addresses on the 8-bit register port)
`define FCSR_ADDR_W 4
`define FCSR_OFF_CONFIG 4'h4
`define FCSR_OFF_ERR_CFG 4'h5
`define FCSR_OFF_STATUS 4'h6
`define FCSR_OFF_FAULT 4'h7

// flash_config fields
`define FCSR_CFG_CMD_IE 7
`define FCSR_CFG_IGN_SF 4
`define FCSR_CFG_FORCE_DF 1
`define FCSR_CFG_FORCE_SF 0
`define FCSR_CFG_MASK 8'h93

// flash_error_irq_config fields
`define FCSR_ERC_DF_IE 1
`define FCSR_ERC_SF_IE 0
`define FCSR_ERC_MASK 8'h03

// flash_status fields
`define FCSR_ST_CMD_DONE 7
`define FCSR_ST_ACC_ERR 5
`define FCSR_ST_PROT_VIOL 4
`define FCSR_ST_BUSY 3
`define FCSR_ST_CSTAT_HI 1
`define FCSR_ST_CSTAT_LO 0

// fault_status_reg fields
`define FCSR_FS_DF 1
`define FCSR_FS_SF 0

// Reset values
`define FCSR_RST_CONFIG 8'h00
`define FCSR_RST_ERR_CFG 8'h00
`define FCSR_RST_CMD_DONE 1'b1

`endif

// >>> logic/fcsr_fault_track.v
`timescale 1ns/1ps
`include "fcsr_defines.vh"

// One write-one-to-clear fault flag with optional forcing on array reads
module fcsr_fault_track (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Read event and fault source
   input wire array_rd,
   input wire real_fault,
   input wire force_en,
   input wire report_en,
   // Software clear
   input wire clr_w1c,
   // Result
   output wire flag,
   output wire ecc_upd
);

   reg flag_ff;
   wire nxt_set;

   // Forcing sets the flag on every read; only a real fault may update the ECC results
   assign nxt_set = report_en & ((array_rd & force_en) | real_fault);
   assign ecc_upd = real_fault;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else if (nxt_set) begin
         flag_ff <= 1'b1;
      end else if (clr_w1c) begin
         flag_ff <= 1'b0;
      end
   end

   assign flag = flag_ff;

endmodule

// >>> logic/fcsr_regs.v
// Overview of operation
// - Command-done enable requests IRQ while flag set
// - Ignore-single-fault suppresses single fault flag and IRQ
// - Force-double sets double flag every array read
// - Forced double read leaves ECC results unchanged
// - Force-single sets single flag every array read
// - Forced single read leaves ECC results unchanged
// - Force bits stay until software writes zero
// - Config bits 7,4,1,0 only; others read zero
// - Double-fault enable requests IRQ while flag set
// - Single-fault enable requests IRQ while flag set
// - Writing one to done flag launches command
// - Access error set on sequence violation or illegal command
// - Access error clears only on write one
// - Access error blocks command launch and done clear
// - Protection violation set on protected write; W1C
// - Protection violation blocks launch and new sequence
// - Busy reads one while controller executes command
// - Completion status set on command or reset error
// - Busy, status read-only; bit 2 reads zero
// - Double fault flag clears only on write one
// - Single fault flag W1C; set on fault or invalid read
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "fcsr_defines.vh"

module fcsr_regs (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Command engine
   input wire cmd_done,
   input wire seq_violation,
   input wire illegal_cmd,
   input wire protect_hit,
   input wire ctrl_busy,
   input wire cstat_set_valid,
   input wire [1:0] cstat_set,
   output reg cmd_launch,
   output reg seq_allow,
   // ECC decoder and array reads
   input wire array_rd,
   input wire dbl_fault,
   input wire sgl_fault,
   input wire invalid_rd,
   output reg ecc_result_upd,
   // Interrupt requests
   output reg cmd_done_irq,
   output reg double_fault_irq,
   output reg single_fault_irq
);

   reg rst_s1_ff;
   reg rst_s2_ff;
   wire rst_n;

   reg [7:0] cfg_ff;
   reg [1:0] ercfg_ff;
   reg cmd_done_flag_ff;
   reg access_error_flag_ff;
   reg protect_violation_flag_ff;
   reg controller_busy_flag_ff;
   reg [1:0] completion_status_ff;

   wire double_fault_flag;
   wire single_fault_flag;
   wire dbl_upd;
   wire sgl_upd;

   wire wr_cfg;
   wire wr_erc;
   wire wr_st;
   wire wr_fs;
   wire launch_req;
   wire nxt_launch;
   wire cmd_ie;
   wire ign_sf;
   wire frc_df;
   wire frc_sf;
   reg [7:0] nxt_rdata;

   function hit;
      input [3:0] a;
      input [3:0] off;
      input we;
      begin
         hit = we & (a == off);
      end
   endfunction

   // Reset is released through two flops so every flop leaves reset on the same edge
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_n = rst_s2_ff;

   assign wr_cfg = hit(reg_addr, `FCSR_OFF_CONFIG, reg_wr);
   assign wr_erc = hit(reg_addr, `FCSR_OFF_ERR_CFG, reg_wr);
   assign wr_st = hit(reg_addr, `FCSR_OFF_STATUS, reg_wr);
   assign wr_fs = hit(reg_addr, `FCSR_OFF_FAULT, reg_wr);

   assign cmd_ie = cfg_ff[`FCSR_CFG_CMD_IE];
   assign ign_sf = cfg_ff[`FCSR_CFG_IGN_SF];
   assign frc_df = cfg_ff[`FCSR_CFG_FORCE_DF];
   assign frc_sf = cfg_ff[`FCSR_CFG_FORCE_SF];

   // Config: only documented bits stored; force bits never self-clear
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= `FCSR_RST_CONFIG;
      end else if (wr_cfg) begin
         cfg_ff <= reg_wdata & `FCSR_CFG_MASK;
      end
   end

   // Error interrupt enables
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ercfg_ff <= 2'h0;
      end else if (wr_erc) begin
         ercfg_ff <= reg_wdata[1:0];
      end
   end

   // Launch: write one to done flag, only when no error flag blocks it
   assign launch_req = wr_st & reg_wdata[`FCSR_ST_CMD_DONE] & cmd_done_flag_ff;
   assign nxt_launch = launch_req & ~access_error_flag_ff
                       & ~protect_violation_flag_ff;

   // Launch pulse to the command engine
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_launch <= 1'b0;
      end else begin
         cmd_launch <= nxt_launch;
      end
   end

   // A new command write sequence is refused while a protection error stands
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seq_allow <= 1'b0;
      end else begin
         seq_allow <= ~protect_violation_flag_ff;
      end
   end

   // Completion or a violation wins over a launch in the same cycle
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_done_flag_ff <= `FCSR_RST_CMD_DONE;
      end else if (cmd_done | seq_violation | illegal_cmd | protect_hit) begin
         cmd_done_flag_ff <= 1'b1;
      end else if (nxt_launch) begin
         cmd_done_flag_ff <= 1'b0;
      end
   end

   // Access error: set wins over a clear in the same cycle
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         access_error_flag_ff <= 1'b0;
      end else if (seq_violation | illegal_cmd) begin
         access_error_flag_ff <= 1'b1;
      end else if (wr_st & reg_wdata[`FCSR_ST_ACC_ERR]) begin
         access_error_flag_ff <= 1'b0;
      end
   end

   // Protection violation: set wins over a clear in the same cycle
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         protect_violation_flag_ff <= 1'b0;
      end else if (protect_hit) begin
         protect_violation_flag_ff <= 1'b1;
      end else if (wr_st & reg_wdata[`FCSR_ST_PROT_VIOL]) begin
         protect_violation_flag_ff <= 1'b0;
      end
   end

   // Busy only while a command runs with the done flag low
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         controller_busy_flag_ff <= 1'b0;
      end else begin
         controller_busy_flag_ff <= ctrl_busy & ~cmd_done_flag_ff;
      end
   end

   // Status bits are loaded by the engine and cleared by a launch, never written by software
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         completion_status_ff <= 2'h0;
      end else if (cstat_set_valid) begin
         completion_status_ff <= cstat_set;
      end else if (nxt_launch) begin
         completion_status_ff <= 2'h0;
      end
   end

   // Double fault flag
   fcsr_fault_track u_dbl (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .array_rd(array_rd),
      .real_fault(dbl_fault | invalid_rd),
      .force_en(frc_df),
      .report_en(1'b1),
      .clr_w1c(wr_fs & reg_wdata[`FCSR_FS_DF]),
      .flag(double_fault_flag),
      .ecc_upd(dbl_upd)
   );

   // Single fault flag; ignore bit masks it entirely
   fcsr_fault_track u_sgl (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .array_rd(array_rd),
      .real_fault(sgl_fault | invalid_rd),
      .force_en(frc_sf),
      .report_en(~ign_sf),
      .clr_w1c(wr_fs & reg_wdata[`FCSR_FS_SF]),
      .flag(single_fault_flag),
      .ecc_upd(sgl_upd)
   );

   // Read mux; unmapped addresses read zero
   always @* begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `FCSR_OFF_CONFIG: begin
            nxt_rdata = cfg_ff & `FCSR_CFG_MASK;
         end
         `FCSR_OFF_ERR_CFG: begin
            nxt_rdata = {6'h00, ercfg_ff};
         end
         `FCSR_OFF_STATUS: begin
            nxt_rdata = {cmd_done_flag_ff,
                         1'b0,
                         access_error_flag_ff,
                         protect_violation_flag_ff,
                         controller_busy_flag_ff,
                         1'b0,
                         completion_status_ff};
         end
         `FCSR_OFF_FAULT: begin
            nxt_rdata = {6'h00, double_fault_flag, single_fault_flag};
         end
         default: begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
      end
   end

   // Forced faults alone never touch the ECC result registers
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ecc_result_upd <= 1'b0;
      end else begin
         ecc_result_upd <= dbl_fault | (sgl_fault & ~ign_sf);
      end
   end

   // IRQs are levels one cycle behind the flags
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_done_irq <= 1'b0;
      end else begin
         cmd_done_irq <= cmd_ie & cmd_done_flag_ff;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         double_fault_irq <= 1'b0;
      end else begin
         double_fault_irq <= ercfg_ff[`FCSR_ERC_DF_IE] & double_fault_flag;
      end
   end

   // Ignore bit gates the request too, in case the flag was set before it
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         single_fault_irq <= 1'b0;
      end else begin
         single_fault_irq <= ercfg_ff[`FCSR_ERC_SF_IE] & single_fault_flag
                             & ~ign_sf;
      end
   end

endmodule

// >>> verification/fcsr_regs_properties.sv
`timescale 1ns/1ps
module fcsr_regs_chk (
   // Clock, reset, register port
   input wire clk_sys,
   input wire resetn,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Engine and ECC side
   input wire protect_hit,
   input wire dbl_fault,
   input wire sgl_fault,
   input wire cmd_launch,
   input wire seq_allow,
   input wire ecc_result_upd,
   // Interrupt requests
   input wire cmd_done_irq,
   input wire double_fault_irq,
   input wire single_fault_irq
);
   reg [7:0] cfg_sh_ff;
   reg [1:0] erc_sh_ff;
   // Shadow enables from bus writes, so no internal probes are needed
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg_sh_ff <= 8'h00;
         erc_sh_ff <= 2'h0;
      end else if (reg_wr && reg_addr == 4'h4) begin
         cfg_sh_ff <= reg_wdata;
      end else if (reg_wr && reg_addr == 4'h5) begin
         erc_sh_ff <= reg_wdata[1:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   chk_launch_cause: assert property (
      cmd_launch |-> $past(reg_wr && reg_addr == 4'h6 && reg_wdata[7])) else $error("stray launch");
   chk_cmd_irq_en: assert property (
      cmd_done_irq |-> $past(cfg_sh_ff[7])) else $error("done irq without enable");
   chk_dbl_irq_en: assert property (
      double_fault_irq |-> $past(erc_sh_ff[1])) else $error("double irq without enable");
   chk_sgl_irq_en: assert property (
      single_fault_irq |-> $past(erc_sh_ff[0] && !cfg_sh_ff[4])) else $error("single irq gated");
   chk_ecc_real_only: assert property (
      ecc_result_upd |-> $past(dbl_fault || sgl_fault)) else $error("ecc update without fault");
   chk_protect_blocks: assert property (
      protect_hit |-> ##[1:2] !seq_allow) else $error("sequence still allowed");
   chk_cfg_rsvd_zero: assert property (
      $past(reg_rd && reg_addr == 4'h4) |-> (reg_rdata & 8'h6c) == 8'h00) else $error("cfg rsvd");
   chk_stat_rsvd_zero: assert property (
      $past(reg_rd && reg_addr == 4'h6) |-> (reg_rdata & 8'h44) == 8'h00) else $error("stat rsvd");
endmodule
bind fcsr_regs fcsr_regs_chk u_chk (.*);

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg clk_sys = 1'b0;
   reg resetn = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg ctrl_busy = 1'b0;
   reg [1:0] cstat_set = 2'h3;
   // Event pulses: done, seqv, illegal, prot, rd, dbl, sgl, invalid, cstat
   reg [8:0] evt = 9'h000;
   reg ecc_seen = 1'b0;
   wire [7:0] reg_rdata;
   wire cmd_launch, seq_allow, ecc_result_upd, cmd_done_irq, double_fault_irq, single_fault_irq;
   integer failures = 0;
   integer checks_done = 0;
   integer i;
   fcsr_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmd_done(evt[0]), .seq_violation(evt[1]), .illegal_cmd(evt[2]), .protect_hit(evt[3]),
      .ctrl_busy(ctrl_busy), .cstat_set_valid(evt[8]), .cstat_set(cstat_set),
      .cmd_launch(cmd_launch), .seq_allow(seq_allow), .array_rd(evt[4]), .dbl_fault(evt[5]),
      .sgl_fault(evt[6]), .invalid_rd(evt[7]), .ecc_result_upd(ecc_result_upd),
      .cmd_done_irq(cmd_done_irq), .double_fault_irq(double_fault_irq),
      .single_fault_irq(single_fault_irq));
   initial forever #4 clk_sys = ~clk_sys;
   task chk(input string name, input [7:0] exp, input [7:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected %s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk_sys);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] a, input [7:0] exp);
      begin
         @(posedge clk_sys);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1;
         chk("rdata", exp, reg_rdata);
      end
   endtask
   // Flags land one edge after the pulse, irqs one edge later
   task pulse(input [8:0] m);
      begin
         @(posedge clk_sys);
         evt <= m;
         @(posedge clk_sys);
         evt <= 9'h000;
         #1;
         ecc_seen = ecc_result_upd;
         repeat (2) @(posedge clk_sys);
         #1;
      end
   endtask
   task t_config;
      begin
         wr(4'h4, 8'hff);
         rd(4'h4, 8'h93);
         wr(4'h5, 8'hff);
         rd(4'h5, 8'h03);
         rd(4'h2, 8'h00);
         wr(4'h6, 8'h44);
         rd(4'h6, 8'h80);
      end
   endtask
   task t_force;
      begin
         wr(4'h4, 8'h03);
         pulse(9'h010);
         chk("ecc_upd", 8'h00, {7'h00, ecc_seen});
         chk("dbl_irq", 8'h01, {7'h00, double_fault_irq});
         chk("sgl_irq", 8'h01, {7'h00, single_fault_irq});
         rd(4'h7, 8'h03);
         rd(4'h4, 8'h03);
         wr(4'h7, 8'h03);
         rd(4'h7, 8'h00);
         chk("dbl_irq", 8'h00, {7'h00, double_fault_irq});
         wr(4'h4, 8'h10);
         pulse(9'h040);
         chk("ecc_upd", 8'h00, {7'h00, ecc_seen});
         rd(4'h7, 8'h00);
         chk("sgl_irq", 8'h00, {7'h00, single_fault_irq});
         wr(4'h4, 8'h00);
         pulse(9'h080);
         rd(4'h7, 8'h03);
         wr(4'h7, 8'h03);
         rd(4'h7, 8'h00);
         pulse(9'h030);
         chk("ecc_upd", 8'h01, {7'h00, ecc_seen});
         chk("dbl_irq", 8'h01, {7'h00, double_fault_irq});
         rd(4'h7, 8'h02);
         wr(4'h7, 8'h03);
      end
   endtask
   task t_launch;
      begin
         pulse(9'h100);
         rd(4'h6, 8'h83);
         wr(4'h4, 8'h80);
         rd(4'h6, 8'h83);
         chk("done_irq", 8'h01, {7'h00, cmd_done_irq});
         wr(4'h6, 8'h80);
         chk("launch", 8'h01, {7'h00, cmd_launch});
         rd(4'h6, 8'h00);
         chk("done_irq", 8'h00, {7'h00, cmd_done_irq});
         @(posedge clk_sys);
         ctrl_busy <= 1'b1;
         rd(4'h6, 8'h08);
         @(posedge clk_sys);
         ctrl_busy <= 1'b0;
         pulse(9'h001);
         rd(4'h6, 8'h80);
         wr(4'h4, 8'h00);
      end
   endtask
   task t_errors;
      begin
         // Both causes of an access error take the same path
         for (i = 1; i < 3; i = i + 1) begin
            pulse(9'h001 << i);
            rd(4'h6, 8'ha0);
            wr(4'h6, 8'h80);
            chk("launch", 8'h00, {7'h00, cmd_launch});
            wr(4'h6, 8'h00);
            rd(4'h6, 8'ha0);
            wr(4'h6, 8'h20);
            rd(4'h6, 8'h80);
         end
         pulse(9'h008);
         chk("seq_allow", 8'h00, {7'h00, seq_allow});
         rd(4'h6, 8'h90);
         wr(4'h6, 8'h80);
         chk("launch", 8'h00, {7'h00, cmd_launch});
         wr(4'h6, 8'h10);
         rd(4'h6, 8'h80);
         chk("seq_allow", 8'h01, {7'h00, seq_allow});
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_config;
      t_force;
      t_launch;
      t_errors;
      final_report;
   end
   initial begin
      #100000;
      failures = failures + 1;
      final_report;
   end
endmodule
